// ### rit_restart_teach.sv
// Restart interlock, self test and blanking teach control of a light-curtain receiver.
// Assumes key inputs are synchronous and debounced; beam evaluation is done elsewhere.
`timescale 1ns/1ps
module rit_restart_teach
	import rit_pkg::*;
#(
	parameter int unsigned     BEAMS          = 16,
	parameter logic [6:0]      RESP_TIME_SEG  = 7'h5b,
	parameter longint unsigned RES_MIN_CYC    = RESET_MIN_CYC,
	parameter longint unsigned RES_MAX_CYC    = RESET_MAX_CYC,
	parameter longint unsigned RES_SHORT_CYC  = RESET_SHORT_CYC,
	parameter longint unsigned TEACH_CYC      = TEACH_WIN_CYC,
	parameter longint unsigned SELFTEST_CYC   = SELF_TEST_CYC
)
(
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic [BEAMS-1:0] beam_blocked,
	input  wire logic             reset_button,
	input  wire logic             teach_key,
	input  wire logic             auto_restart,
	input  wire logic             align_mode,
	input  wire logic             self_test_fail,
	output logic                  safety_switching_output,
	output logic                  primary_status_green,
	output logic                  primary_status_red,
	output logic                  primary_status_flash,
	output logic                  restart_interlock_yellow,
	output logic [6:0]            segment_display,
	output logic                  segment_flash,
	output logic [BEAMS-1:0]      fixed_blank,
	output logic [BEAMS-1:0]      floating_blank,
	output logic                  fault
);

	rit_state_type        state;
	rit_state_type        next_state;
	logic [CNT_W-1:0]     st_cnt;
	logic [CNT_W-1:0]     teach_cnt;
	logic                 res_ok;
	logic                 res_stuck;
	logic                 teach_rel;
	logic                 teach_q;
	logic [BEAMS-1:0]     ever_blk;
	logic [BEAMS-1:0]     always_blk;
	logic [BEAMS-1:0]     ever_merged;
	logic [BEAMS-1:0]     fixed_merged;
	logic                 field_clear;

	assign field_clear = ~|(beam_blocked & ~fixed_blank & ~floating_blank);

	rit_press_timer
	#(
		.MIN_CYC  (RES_MIN_CYC),
		.MAX_CYC  (RES_MAX_CYC),
		.LONG_CYC (RES_SHORT_CYC)
	)
	u_reset_timer
	(
		.clk_sys       (clk_sys),
		.sys_rst       (sys_rst),
		.key           (reset_button),
		.valid_release (res_ok),
		.held_long     (res_stuck)
	);

	rit_blank_merge #(.BEAMS(BEAMS)) u_merge_float
	(
		.blanked (ever_blk),
		.merged  (ever_merged)
	);

	rit_blank_merge #(.BEAMS(BEAMS)) u_merge_fixed
	(
		.blanked (always_blk),
		.merged  (fixed_merged)
	);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			teach_q <= 1'b0;
		else
			teach_q <= teach_key;
	end
	assign teach_rel = teach_q && !teach_key;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || state != RIT_SELF_TEST)
			st_cnt <= '0;
		else
			st_cnt <= st_cnt + CNT_W'(1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || state != RIT_TEACH)
			teach_cnt <= '0;
		else if (teach_cnt < CNT_W'(TEACH_CYC))
			teach_cnt <= teach_cnt + CNT_W'(1);
	end

	always_comb
	begin
		next_state = state;
		case (state)
			RIT_SELF_TEST:
			begin
				if (self_test_fail)
					next_state = RIT_FAULT;
				else if (st_cnt >= CNT_W'(SELFTEST_CYC))
					next_state = RIT_LOCKED;
			end
			RIT_LOCKED:
			begin
				if (res_stuck)
					next_state = RIT_FAULT;
				else if (teach_rel)
					next_state = RIT_TEACH;
				else if (field_clear && (auto_restart || res_ok))
					next_state = RIT_ON;
			end
			// A blocked beam that is not blanked drops the outputs; automatic restart brings them back.
			RIT_ON:
			begin
				if (res_stuck)
					next_state = RIT_FAULT;
				else if (!field_clear)
					next_state = RIT_LOCKED;
			end
			RIT_TEACH:
			begin
				if (teach_rel)
					next_state = RIT_LOCKED;
				else if (teach_cnt >= CNT_W'(TEACH_CYC))
					next_state = RIT_LOCKED;
			end
			RIT_FAULT:
				next_state = RIT_FAULT;
			default:
				next_state = RIT_FAULT;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			state <= RIT_SELF_TEST;
		else
			state <= next_state;
	end

	// Teach capture: union and intersection of blocked beams over the window.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			ever_blk   <= '0;
			always_blk <= '0;
		end
		else if (state != RIT_TEACH)
		begin
			ever_blk   <= '0;
			always_blk <= '1;
		end
		else if (teach_cnt < CNT_W'(TEACH_CYC))
		begin
			ever_blk   <= ever_blk | beam_blocked;
			always_blk <= always_blk & beam_blocked;
		end
	end

	// Stored configuration changes only on an accepted teach or a system reset, which clears it; a timeout keeps it.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			fixed_blank    <= '0;
			floating_blank <= '0;
		end
		else if (state == RIT_TEACH && teach_rel && teach_cnt < CNT_W'(TEACH_CYC))
		begin
			fixed_blank    <= fixed_merged & always_blk;
			floating_blank <= ever_merged & ~always_blk;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			safety_switching_output  <= 1'b0;
			primary_status_green     <= 1'b0;
			primary_status_red       <= 1'b0;
			primary_status_flash     <= 1'b0;
			restart_interlock_yellow <= 1'b0;
			fault                    <= 1'b0;
		end
		else
		begin
			safety_switching_output  <= next_state == RIT_ON;
			primary_status_green     <= next_state == RIT_ON;
			primary_status_red       <= next_state != RIT_ON
				&& next_state != RIT_SELF_TEST;
			primary_status_flash     <= align_mode && next_state != RIT_FAULT;
			restart_interlock_yellow <= next_state == RIT_LOCKED && field_clear;
			fault                    <= next_state == RIT_FAULT;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			segment_display <= SEG_BLANK;
			segment_flash   <= 1'b0;
		end
		else if (next_state == RIT_SELF_TEST)
		begin
			segment_display <= SEG_DASH;
			segment_flash   <= 1'b0;
		end
		else if (align_mode)
		begin
			segment_display <= SEG_ALIGN;
			segment_flash   <= 1'b1;
		end
		else
		begin
			segment_display <= RESP_TIME_SEG;
			segment_flash   <= 1'b0;
		end
	end

	chk_restart_needs_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == RIT_LOCKED && !auto_restart && !res_ok && next_state == RIT_ON) |-> 1'b0)
		else $error("restart without valid release");

	chk_stuck_to_fault: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == RIT_LOCKED && res_stuck) |=> fault)
		else $error("stuck reset did not fault");

	chk_red_when_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == RIT_LOCKED) |=> (primary_status_red || state == RIT_ON))
		else $error("red not lit while locked");

	chk_output_matches_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
		safety_switching_output |-> (state == RIT_ON))
		else $error("output on outside ON state");

	chk_teach_timeout: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == RIT_TEACH && teach_cnt >= CNT_W'(TEACH_CYC)) |=> state == RIT_LOCKED)
		else $error("teach did not abort");

	chk_timeout_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == RIT_TEACH && !teach_rel) |=> $stable(fixed_blank) && $stable(floating_blank))
		else $error("config changed without accept");

	chk_yellow_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
		restart_interlock_yellow |-> primary_status_red && !safety_switching_output)
		else $error("yellow without lock");

	chk_align_flash: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(align_mode && state != RIT_SELF_TEST && next_state != RIT_SELF_TEST) |=> segment_flash)
		else $error("align without flash");

	chk_auto_restart_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == RIT_LOCKED && auto_restart && field_clear && !res_stuck && !teach_rel)
		|=> safety_switching_output)
		else $error("automatic restart did not switch on");

	chk_green_steady_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == RIT_ON) |-> (primary_status_green && !primary_status_red))
		else $error("status colour not steady in ON");

	chk_blank_disjoint: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(fixed_blank & floating_blank) == '0)
		else $error("beam both fixed and floating");

	chk_fault_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fault |=> fault)
		else $error("fault cleared without reset");

endmodule // rit_restart_teach

// ### rit_pkg.sv
// Package for the restart interlock and teach control block.
// Holds state encodings, timing figures and derived cycle counts at the 250 MHz system clock.
package rit_pkg;

	localparam int unsigned CLK_HZ = 250_000_000;

	// Press timing in milliseconds, as printed.
	localparam int unsigned RESET_MIN_MS   = 150;
	localparam int unsigned RESET_MAX_MS   = 4000;
	localparam int unsigned RESET_SHORT_MS = 30000;
	localparam int unsigned TEACH_WIN_MS   = 60000;

	// Every figure is an exact multiple of the cycles per millisecond; nothing is rounded.
	localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam longint unsigned RESET_MIN_CYC   = RESET_MIN_MS * CYC_PER_MS;
	localparam longint unsigned RESET_MAX_CYC   = RESET_MAX_MS * CYC_PER_MS;
	localparam longint unsigned RESET_SHORT_CYC = RESET_SHORT_MS * CYC_PER_MS;
	localparam longint unsigned TEACH_WIN_CYC   = TEACH_WIN_MS * CYC_PER_MS;

	// Self test length in cycles; no figure is given, kept short.
	localparam longint unsigned SELF_TEST_CYC = 64'd1024;

	localparam int unsigned CNT_W = 40;

	// Seven-segment patterns, active high, segments g..a.
	localparam logic [6:0] SEG_BLANK = 7'h00;
	localparam logic [6:0] SEG_DASH  = 7'h40;
	localparam logic [6:0] SEG_ALIGN = 7'h49;

	typedef enum logic [4:0]
	{
		RIT_SELF_TEST = 5'h01,
		RIT_LOCKED    = 5'h02,
		RIT_ON        = 5'h04,
		RIT_FAULT     = 5'h08,
		RIT_TEACH     = 5'h10
	} rit_state_type;

endpackage

// ### rit_press_timer.sv
// Press timer: measures how long an active-high key input stays pressed.
// Assumes the key input is already synchronous and debounced.
`timescale 1ns/1ps
module rit_press_timer
	import rit_pkg::*;
#(
	parameter longint unsigned MIN_CYC  = RESET_MIN_CYC,
	parameter longint unsigned MAX_CYC  = RESET_MAX_CYC,
	parameter longint unsigned LONG_CYC = RESET_SHORT_CYC
)
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic key,
	output logic      valid_release,
	output logic      held_long
);

	logic             key_q;
	logic [CNT_W-1:0] hold_cnt;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			key_q <= 1'b0;
		else
			key_q <= key;
	end

	// The counter saturates so a stuck key never wraps into a valid window.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !key)
			hold_cnt <= '0;
		else if (hold_cnt < CNT_W'(LONG_CYC))
			hold_cnt <= hold_cnt + CNT_W'(1);
	end

	// A release counts only inside the window; shorter or longer presses vanish.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			valid_release <= 1'b0;
		else
			valid_release <= key_q && !key && hold_cnt >= CNT_W'(MIN_CYC)
				&& hold_cnt <= CNT_W'(MAX_CYC);
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			held_long <= 1'b0;
		else
			held_long <= key && hold_cnt >= CNT_W'(LONG_CYC);
	end

endmodule // rit_press_timer

// ### rit_blank_merge.sv
// Blanking merge: passes the blanked beams through unchanged; adjacent blanked beams already form one area.
// Two areas stay apart only where at least one unblanked beam lies between them.
`timescale 1ns/1ps
module rit_blank_merge
	import rit_pkg::*;
#(
	parameter int unsigned BEAMS = 16
)
(
	input  wire logic [BEAMS-1:0] blanked,
	output logic      [BEAMS-1:0] merged
);

	// Areas are sets of beams, so any unblanked beam already separates them.
	// Merging therefore keeps every blanked beam and never bridges a clear one.
	always_comb
	begin
		merged = blanked;
	end

endmodule // rit_blank_merge

// ### rit_operator.sv
// Operator model: the reset button and the teach key switch.
// Assumes clk_sys from the bench; every change lands 1 ns after a rising edge.
`timescale 1ns/1ps
module rit_operator
(
	input  wire logic clk_sys,
	output logic      reset_button,
	output logic      teach_key
);
	initial
	begin
		reset_button = 1'b0;
		teach_key    = 1'b0;
	end

	// Holds one key for n cycles, then lets go. The bench picks n inside or outside the
	// accepted span on purpose, so this model never corrects a press length.
	task automatic press(input bit teach, input int n);
		@(posedge clk_sys);
		#1;
		if (teach)
			teach_key = 1'b1;
		else
			reset_button = 1'b1;
		repeat (n) @(posedge clk_sys);
		#1;
		teach_key    = 1'b0;
		reset_button = 1'b0;
	endtask
endmodule // rit_operator

// ### tb_top.sv
// Self-checking bench for the restart interlock and teach control block.
// Assumes shortened timings: press span 5 to 20, short circuit 50, teach window 100 cycles.
`timescale 1ns/1ps
module tb_top;
	import rit_pkg::*;

	localparam logic [6:0] RESP = 7'h5b;

	logic        clk_sys;
	logic        sys_rst;
	logic [15:0] beam_blocked;
	logic        reset_button;
	logic        teach_key;
	logic        auto_restart;
	logic        align_mode;
	logic        self_test_fail;
	logic        ssw;
	logic        green;
	logic        red;
	logic        pflash;
	logic        yellow;
	logic [6:0]  seg;
	logic        sflash;
	logic [15:0] fixed_blank;
	logic [15:0] floating_blank;
	logic        fault;
	int          errors;
	int          n_tests;
	int          cycles;

	rit_restart_teach #(
		.RESP_TIME_SEG(RESP), .RES_MIN_CYC(5), .RES_MAX_CYC(20),
		.RES_SHORT_CYC(50), .TEACH_CYC(100), .SELFTEST_CYC(8)
	) rit_restart_teach_i (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .beam_blocked(beam_blocked),
		.reset_button(reset_button), .teach_key(teach_key), .auto_restart(auto_restart),
		.align_mode(align_mode), .self_test_fail(self_test_fail),
		.safety_switching_output(ssw), .primary_status_green(green),
		.primary_status_red(red), .primary_status_flash(pflash),
		.restart_interlock_yellow(yellow), .segment_display(seg), .segment_flash(sflash),
		.fixed_blank(fixed_blank), .floating_blank(floating_blank), .fault(fault)
	);

	rit_operator rit_operator_i (
		.clk_sys(clk_sys), .reset_button(reset_button), .teach_key(teach_key)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic end_of_test();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// The whole run needs well under a thousand cycles.
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			$display("[ERR] %0t run did not finish", $time);
			end_of_test();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic t_power();
		cyc(12);
		check(seg, RESP);
		check({red, green, pflash}, 3'b100);
		check({red, ssw}, 2'b10);
		check(yellow, 1'b1);
	endtask

	task automatic t_reset();
		rit_operator_i.press(1'b0, 3);
		cyc(4);
		check({ssw, red}, 2'b01);
		rit_operator_i.press(1'b0, 30);
		cyc(4);
		check({ssw, red, fault}, 3'b010);
		rit_operator_i.press(1'b0, 10);
		cyc(3);
		check({ssw, green, red}, 3'b110);
	endtask

	task automatic t_auto();
		beam_blocked = 16'h0010;
		cyc(3);
		check({ssw, red}, 2'b01);
		auto_restart = 1'b1;
		beam_blocked = 16'h0000;
		cyc(4);
		check(ssw, 1'b1);
		beam_blocked = 16'h0010;
		cyc(3);
		check(ssw, 1'b0);
		auto_restart = 1'b0;
		beam_blocked = 16'h0000;
		cyc(4);
		check({ssw, yellow}, 2'b01);
	endtask

	task automatic t_align();
		align_mode = 1'b1;
		cyc(3);
		check(sflash, 1'b1);
		check(seg, SEG_ALIGN);
		align_mode = 1'b0;
		cyc(3);
		check({sflash, pflash}, 2'b00);
	endtask

	// One full teach: the first press opens, the second accepts.
	task automatic teach(input logic [15:0] field, input bit moving);
		beam_blocked = field;
		rit_operator_i.press(1'b1, 10);
		repeat (4)
		begin
			beam_blocked[8] = moving;
			cyc(2);
			beam_blocked[8] = 1'b0;
			cyc(2);
		end
		rit_operator_i.press(1'b1, 10);
		cyc(4);
		beam_blocked = 16'h0000;
	endtask

	task automatic t_teach();
		// Beam 2 stays clear, so the two fixed areas must not join.
		teach(16'h000b, 1'b1);
		check(fixed_blank, 16'h000b);
		check(floating_blank, 16'h0100);
		teach(16'h0020, 1'b0);
		check(fixed_blank, 16'h0020);
		check(floating_blank, 16'h0000);
		beam_blocked = 16'h0080;
		rit_operator_i.press(1'b1, 10);
		cyc(110);
		beam_blocked = 16'h0000;
		cyc(4);
		check(fixed_blank, 16'h0020);
		teach(16'h0000, 1'b0);
		check(fixed_blank | floating_blank, 16'h0000);
	endtask

	task automatic t_fault();
		rit_operator_i.press(1'b0, 60);
		cyc(3);
		check({fault, ssw}, 2'b10);
	endtask

	// A second reset in mid-run; a failing self test must end in the fault state.
	task automatic t_selftest();
		sys_rst = 1'b1;
		cyc(2);
		check({fault, red, ssw}, 3'b000);
		sys_rst = 1'b0;
		cyc(3);
		check(seg, SEG_DASH);
		check({red, green, fault}, 3'b000);
		self_test_fail = 1'b1;
		cyc(2);
		check({fault, ssw}, 2'b10);
		self_test_fail = 1'b0;
	endtask

	initial
	begin
		errors       = 0;
		n_tests      = 0;
		cycles       = 0;
		sys_rst      = 1'b1;
		beam_blocked = 16'h0000;
		auto_restart = 1'b0;
		align_mode   = 1'b0;
		self_test_fail = 1'b0;
		cyc(8);
		sys_rst = 1'b0;
		t_power();
		t_reset();
		t_auto();
		t_align();
		t_teach();
		t_fault();
		t_selftest();
		end_of_test();
	end
endmodule // tb_top
